// File: dacwd_ctrl_model.sv
// serial controller model that frames input words for the decoder
`timescale 1ns/100ps
module dacwd_ctrl_model (
    // clock
    input wire logic clk_in,
    // serial link
    output logic sclk_out,
    output logic sdin_out,
    output logic sync_n_out
);
    // idle link: serial clock parked low, frame high
    initial begin
        sclk_out = 1'b0;
        sdin_out = 1'b0;
        sync_n_out = 1'b1;
    end
    // one frame, msb first, two cycles per clock phase
    task automatic send(input logic [31:0] w, input int n);
        @(negedge clk_in) sync_n_out <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk_in) sclk_out <= 1'b1;
            sdin_out <= w[i];
            @(negedge clk_in);
            @(negedge clk_in) sclk_out <= 1'b0;
            @(negedge clk_in);
        end
        @(negedge clk_in) sync_n_out <= 1'b1;
        sdin_out <= ~sdin_out; // released data line shows the inverse
    endtask : send
endmodule : dacwd_ctrl_model

// File: dacwd_pkg.sv
// package of constants and types for the dac input word decoder
//
// Notes on behaviour
// RL1: controller resets the device after power-on before any other configuration.
// RL2: controller sets up boost converter frequency, voltage limit and phase before channels.
// RL3: controller writes channel control with range, converter and circuitry enabled, output off.
// RL4: a dac data write starts a full internal calibration of that channel.
// RL5: controller waits at least 200 us after the code before enabling output.
// RL6: controller finally rewrites channel control with output drive enable set.
// RL7: range change repeats channel control, data and enable steps, not converter setup.
// RL8: controller should bring the channel to zero scale before disabling output.
// RL9: words are 24 bits, or 32 with checksum, whose last eight bits are checksum.
// RL10: layout is rw, device address, register select, channel select, 16 data bits.
// RL11: dac data write loads the low sixteen word bits as the channel code.
// RL12: a word acts only when its device address equals the two address pins.
// RL13: register select picks data or control registers; control uses a further sub-field.
// RL14: word bits irrelevant to the operation are ignored.
// RL15: register select zero writes only the one named channel's dac code.
// RL16: select 010 writes one gain register, 011 writes all four.
// RL17: select 100 writes one offset register, 101 writes all four.
// RL18: channel select zero to three addresses the first to fourth channel.
package dacwd_pkg;
    // word sizes
    localparam int WORD_BITS = 24;
    localparam int CHK_WORD_BITS = 32;
    localparam int CHK_BITS = 8;
    localparam int DATA_W = 16;
    localparam int NCH = 4;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
    localparam logic [CNT_W-1:0] CNT_WORD = 6'h18;
    localparam logic [CNT_W-1:0] CNT_CHK = 6'h20;
    // register select codes
    localparam logic [2:0] SEL_DAC = 3'h0;
    localparam logic [2:0] SEL_GAIN = 3'h2;
    localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
    localparam logic [2:0] SEL_OFS = 3'h4;
    localparam logic [2:0] SEL_OFS_ALL = 3'h5;
    localparam logic [2:0] SEL_CLR = 3'h6;
    localparam logic [2:0] SEL_CTRL = 3'h7;
    localparam logic RW_WRITE = 1'h0;
    // reset values of the data registers
    localparam logic [DATA_W-1:0] DAC_RST = 16'h0000;
    localparam logic [DATA_W-1:0] GAIN_RST = 16'hFFFF;
    localparam logic [DATA_W-1:0] OFS_RST = 16'h8000;
    localparam logic [DATA_W-1:0] CLR_RST = 16'h0000;
    // input word, msb first
    typedef struct packed {
        logic rw;
        logic [1:0] dev_addr;
        logic [2:0] reg_sel;
        logic [1:0] chan_sel;
        logic [DATA_W-1:0] data;
    } dacwd_word_s;
    // frame tracking states
    typedef enum logic [1:0] {
        FR_IDLE = 2'b01,
        FR_SHIFT = 2'b10
    } dacwd_frame_e;
endpackage : dacwd_pkg

// File: dacwd_top.sv
// serial input word decoder with per-channel data registers
`timescale 1ns/100ps
module dacwd_top (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    // serial link
    input wire logic SCLK_IN,
    input wire logic SDIN_IN,
    input wire logic SYNC_N_IN,
    // straps and mode
    input wire logic ADDR_PIN_HI_IN,
    input wire logic ADDR_PIN_LO_IN,
    input wire logic PACKET_CHECKSUM_IN,
    // channel data registers
    output logic [dacwd_pkg::NCH*dacwd_pkg::DATA_W-1:0] DAC_CODE_OUT,
    output logic [dacwd_pkg::NCH*dacwd_pkg::DATA_W-1:0] GAIN_OUT,
    output logic [dacwd_pkg::NCH*dacwd_pkg::DATA_W-1:0] OFFSET_OUT,
    output logic [dacwd_pkg::NCH*dacwd_pkg::DATA_W-1:0] CLEAR_CODE_OUT,
    // calibration and control strobes
    output logic [dacwd_pkg::NCH-1:0] CAL_START_OUT,
    output logic CTRL_WR_OUT,
    output logic [1:0] CTRL_CHAN_OUT,
    output logic [dacwd_pkg::DATA_W-1:0] CTRL_DATA_OUT,
    output logic RD_REQ_OUT
);

    // ****************************************
    // frame capture
    // ****************************************
    dacwd_pkg::dacwd_frame_e state_r;
    logic sclk_d_r;
    logic [dacwd_pkg::CHK_WORD_BITS-1:0] shift_r;
    logic [dacwd_pkg::CNT_W-1:0] cnt_r;
    logic sclk_fall;
    logic frame_end;
    logic len_ok;
    logic addr_ok;
    logic wr_ok;
    dacwd_pkg::dacwd_word_s word;

    // shift on falling serial clock inside a frame
    assign sclk_fall = sclk_d_r && !SCLK_IN;
    assign frame_end = (state_r == dacwd_pkg::FR_SHIFT) && SYNC_N_IN;

    // remember serial clock level for edge detection
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            sclk_d_r <= 1'h0;
        end else begin
            sclk_d_r <= SCLK_IN;
        end
    end

    // frame state follows the sync line
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state_r <= dacwd_pkg::FR_IDLE;
        end else begin
            case (state_r)
                dacwd_pkg::FR_IDLE: begin
                    if (!SYNC_N_IN) begin
                        state_r <= dacwd_pkg::FR_SHIFT;
                    end
                end
                dacwd_pkg::FR_SHIFT: begin
                    if (SYNC_N_IN) begin
                        state_r <= dacwd_pkg::FR_IDLE;
                    end
                end
                default: begin
                    state_r <= dacwd_pkg::FR_IDLE;
                end
            endcase
        end
    end

    // shift register and saturating bit counter
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            shift_r <= '0;
            cnt_r <= '0;
        end else if (state_r == dacwd_pkg::FR_IDLE) begin
            cnt_r <= '0;
        end else if (sclk_fall && !SYNC_N_IN) begin
            shift_r <= {shift_r[dacwd_pkg::CHK_WORD_BITS-2:0], SDIN_IN};
            if (cnt_r != dacwd_pkg::CNT_MAX) begin
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end

    // ****************************************
    // word decode
    // ****************************************
    // with checksum on, the trailing byte is dropped unchecked
    assign word = PACKET_CHECKSUM_IN ?
        dacwd_pkg::dacwd_word_s'(shift_r[dacwd_pkg::CHK_WORD_BITS-1:dacwd_pkg::CHK_BITS]) :
        dacwd_pkg::dacwd_word_s'(shift_r[dacwd_pkg::WORD_BITS-1:0]); // see RL9 see RL10
    assign len_ok = PACKET_CHECKSUM_IN ? (cnt_r == dacwd_pkg::CNT_CHK) : (cnt_r == dacwd_pkg::CNT_WORD); // see RL9
    assign addr_ok = word.dev_addr == {ADDR_PIN_HI_IN, ADDR_PIN_LO_IN}; // see RL12
    assign wr_ok = frame_end && len_ok && addr_ok && (word.rw == dacwd_pkg::RW_WRITE);

    // ****************************************
    // per-channel data registers
    // ****************************************
    logic [dacwd_pkg::DATA_W-1:0] dac_r [dacwd_pkg::NCH];
    logic [dacwd_pkg::DATA_W-1:0] gain_r [dacwd_pkg::NCH];
    logic [dacwd_pkg::DATA_W-1:0] ofs_r [dacwd_pkg::NCH];
    logic [dacwd_pkg::DATA_W-1:0] clr_r [dacwd_pkg::NCH];
    logic [dacwd_pkg::NCH-1:0] cal_r;

    genvar g;
    generate
        for (g = 0; g < dacwd_pkg::NCH; g++) begin : g_ch
            logic hit;
            // channel select value matches this channel index
            assign hit = word.chan_sel == 2'(g); // see RL18

            // dac code: single channel write only
            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    dac_r[g] <= dacwd_pkg::DAC_RST;
                    cal_r[g] <= 1'h0;
                end else begin
                    cal_r[g] <= wr_ok && (word.reg_sel == dacwd_pkg::SEL_DAC) && hit; // see RL4
                    if (wr_ok && (word.reg_sel == dacwd_pkg::SEL_DAC) && hit) begin
                        dac_r[g] <= word.data; // see RL11 see RL15
                    end
                end
            end

            // gain, offset and clear code trims
            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    gain_r[g] <= dacwd_pkg::GAIN_RST;
                    ofs_r[g] <= dacwd_pkg::OFS_RST;
                    clr_r[g] <= dacwd_pkg::CLR_RST;
                end else if (wr_ok) begin
                    if ((word.reg_sel == dacwd_pkg::SEL_GAIN && hit) || word.reg_sel == dacwd_pkg::SEL_GAIN_ALL) begin
                        gain_r[g] <= word.data; // see RL16
                    end
                    if ((word.reg_sel == dacwd_pkg::SEL_OFS && hit) || word.reg_sel == dacwd_pkg::SEL_OFS_ALL) begin
                        ofs_r[g] <= word.data; // see RL17
                    end
                    if (word.reg_sel == dacwd_pkg::SEL_CLR && hit) begin
                        clr_r[g] <= word.data; // see RL13
                    end
                end
            end

            // flatten registers onto the output buses
            assign DAC_CODE_OUT[g*dacwd_pkg::DATA_W +: dacwd_pkg::DATA_W] = dac_r[g];
            assign GAIN_OUT[g*dacwd_pkg::DATA_W +: dacwd_pkg::DATA_W] = gain_r[g];
            assign OFFSET_OUT[g*dacwd_pkg::DATA_W +: dacwd_pkg::DATA_W] = ofs_r[g];
            assign CLEAR_CODE_OUT[g*dacwd_pkg::DATA_W +: dacwd_pkg::DATA_W] = clr_r[g];
        end
    endgenerate

    assign CAL_START_OUT = cal_r;

    // ****************************************
    // control hand-off and read request
    // ****************************************
    logic ctrl_wr_r;
    logic [1:0] ctrl_chan_r;
    logic [dacwd_pkg::DATA_W-1:0] ctrl_data_r;
    logic rd_req_r;

    // control words pass channel select and data to the control register decoder
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ctrl_wr_r <= 1'h0;
            ctrl_chan_r <= 2'h0;
            ctrl_data_r <= '0;
            rd_req_r <= 1'h0;
        end else begin
            ctrl_wr_r <= wr_ok && (word.reg_sel == dacwd_pkg::SEL_CTRL); // see RL13
            rd_req_r <= frame_end && len_ok && addr_ok && (word.rw != dacwd_pkg::RW_WRITE);
            if (wr_ok && (word.reg_sel == dacwd_pkg::SEL_CTRL)) begin
                ctrl_chan_r <= word.chan_sel;
                ctrl_data_r <= word.data; // see RL14
            end
        end
    end

    assign CTRL_WR_OUT = ctrl_wr_r;
    assign CTRL_CHAN_OUT = ctrl_chan_r;
    assign CTRL_DATA_OUT = ctrl_data_r;
    assign RD_REQ_OUT = rd_req_r;

    // ****************************************
    // checks
    // ****************************************
    sequence dac_write_seq;
        wr_ok && word.reg_sel == dacwd_pkg::SEL_DAC;
    endsequence

    sequence foreign_word_seq;
        frame_end && !addr_ok;
    endsequence

    dac_code_load_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL11
        dac_write_seq |=>
        DAC_CODE_OUT[$past(word.chan_sel)*dacwd_pkg::DATA_W +: dacwd_pkg::DATA_W] == $past(word.data))
        else $error("dac code not loaded");
    cal_start_pulse_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL4
        dac_write_seq |=> $onehot(CAL_START_OUT) ##1 CAL_START_OUT == 4'h0)
        else $error("calibration strobe wrong");
    single_chan_only_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL15
        $rose(CAL_START_OUT[0]) |-> $stable(DAC_CODE_OUT[dacwd_pkg::NCH*dacwd_pkg::DATA_W-1:dacwd_pkg::DATA_W]))
        else $error("other channel changed");
    addr_mismatch_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL12
        foreign_word_seq |=> $stable(DAC_CODE_OUT) && $stable(GAIN_OUT) && !CTRL_WR_OUT)
        else $error("foreign word acted on");
    gain_all_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL16
        wr_ok && word.reg_sel == dacwd_pkg::SEL_GAIN_ALL |=> GAIN_OUT == {4{$past(word.data)}})
        else $error("gain broadcast failed");
    offset_all_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL17
        wr_ok && word.reg_sel == dacwd_pkg::SEL_OFS_ALL |=> OFFSET_OUT == {4{$past(word.data)}})
        else $error("offset broadcast failed");
    length_check_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL9
        frame_end && !len_ok |=> !CTRL_WR_OUT && CAL_START_OUT == 4'h0 && !RD_REQ_OUT)
        else $error("bad length word accepted");
    ctrl_pass_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL13
        CTRL_WR_OUT |-> CTRL_DATA_OUT == $past(word.data) && $stable(DAC_CODE_OUT))
        else $error("control word mishandled");
    chan_map_a: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see RL18
        dac_write_seq |=> CAL_START_OUT[$past(word.chan_sel)])
        else $error("channel mapping wrong");

endmodule : dacwd_top

// File: dacwd_top_test.sv
// self-checking bench for the dac input word decoder
`timescale 1ns/100ps
module dacwd_top_test;
    // ****************
    // signals
    // ****************
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sclk, sdin, sync_n, cwr, rdq;
    logic a_hi = 1'b1;
    logic a_lo = 1'b0;
    logic chk_on = 1'b0;
    logic [63:0] dac, gain, ofs, clr, e_dac, e_gain, e_ofs, e_clr;
    logic [3:0] cal;
    logic [1:0] cch;
    logic [15:0] cdat;
    int n_fail = 0;
    int compares = 0;
    dacwd_top i_dacwd_top (.CLK_IN(clk), .SRST_IN(srst), .SCLK_IN(sclk), .SDIN_IN(sdin),
        .SYNC_N_IN(sync_n), .ADDR_PIN_HI_IN(a_hi), .ADDR_PIN_LO_IN(a_lo), .PACKET_CHECKSUM_IN(chk_on),
        .DAC_CODE_OUT(dac), .GAIN_OUT(gain), .OFFSET_OUT(ofs), .CLEAR_CODE_OUT(clr),
        .CAL_START_OUT(cal), .CTRL_WR_OUT(cwr), .CTRL_CHAN_OUT(cch), .CTRL_DATA_OUT(cdat), .RD_REQ_OUT(rdq));
    dacwd_ctrl_model i_dacwd_ctrl_model (.clk_in(clk), .sclk_out(sclk), .sdin_out(sdin), .sync_n_out(sync_n));
    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    // compare one value
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // compare all channel data register outputs
    task automatic cmp_regs();
        check(dac, e_dac);
        check(gain, e_gain);
        check(ofs, e_ofs);
        check(clr, e_clr);
    endtask : cmp_regs
    // word for this device
    function automatic logic [31:0] wd(input logic [2:0] s, input logic [1:0] c, input logic [15:0] d);
        return {8'h00, 1'b0, a_hi, a_lo, s, c, d};
    endfunction : wd
    // send a word, count pulses over eight cycles, compare
    task automatic xfer(input logic [31:0] w, input int n, input logic [3:0] ec, input logic [3:0] ew,
        input logic [3:0] er);
        logic [3:0] seen, kc, kw, kr;
        seen = 4'h0;
        kc = 4'h0;
        kw = 4'h0;
        kr = 4'h0;
        i_dacwd_ctrl_model.send(w, n);
        repeat (8) begin
            @(negedge clk);
            seen = seen | cal;
            kc = kc + 4'($countones(cal));
            kw = kw + {3'h0, cwr};
            kr = kr + {3'h0, rdq};
        end
        check(seen, ec);
        check(kc, 4'($countones(ec)));
        check(kw, ew);
        check(kr, er);
        cmp_regs();
    endtask : xfer
    // power-on bring-up and a range change
    task automatic t_bringup();
        xfer(wd(dacwd_pkg::SEL_CTRL, 2'h0, 16'h0123), 24, 4'h0, 4'h1, 4'h0);
        xfer(wd(dacwd_pkg::SEL_CTRL, 2'h1, 16'h1234), 24, 4'h0, 4'h1, 4'h0);
        check(cch, 64'h1);
        check(cdat, 64'h1234);
        e_dac[31:16] = 16'hBEEF;
        xfer(wd(dacwd_pkg::SEL_DAC, 2'h1, 16'hBEEF), 24, 4'h2, 4'h0, 4'h0);
        repeat (25000) @(negedge clk);
        xfer(wd(dacwd_pkg::SEL_CTRL, 2'h1, 16'h1334), 24, 4'h0, 4'h1, 4'h0);
        e_dac[31:16] = 16'h0000;
        xfer(wd(dacwd_pkg::SEL_DAC, 2'h1, 16'h0000), 24, 4'h2, 4'h0, 4'h0);
        xfer(wd(dacwd_pkg::SEL_CTRL, 2'h1, 16'h1235), 24, 4'h0, 4'h1, 4'h0);
        check(cdat, 64'h1235);
        $display("bring-up test done");
    endtask : t_bringup
    // each channel code lands in its own slot
    task automatic t_chan();
        for (int c = 0; c < 4; c++) begin
            e_dac[16*c +: 16] = 16'h1000 * 16'(c) + 16'h00A5;
            xfer(wd(dacwd_pkg::SEL_DAC, 2'(c), e_dac[16*c +: 16]), 24, 4'h1 << c, 4'h0, 4'h0);
        end
        $display("channel test done");
    endtask : t_chan
    // trim and clear selects, broadcasts, unused select
    task automatic t_trim();
        logic [2:0] tbl [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1};
        logic [15:0] d;
        logic [1:0] c;
        for (int i = 0; i < 6; i++) begin
            d = 16'h3C10 + 16'(i);
            c = 2'(i + 1);
            case (tbl[i])
                3'h2: e_gain[16*c +: 16] = d;
                3'h3: e_gain = {4{d}};
                3'h4: e_ofs[16*c +: 16] = d;
                3'h5: e_ofs = {4{d}};
                3'h6: e_clr[16*c +: 16] = d;
                default: ;
            endcase
            xfer(wd(tbl[i], c, d), 24, 4'h0, 4'h0, 4'h0);
        end
        $display("trim test done");
    endtask : t_trim
    // address mismatch, bad counts, read, checksum words
    task automatic t_refuse();
        xfer({8'h00, 1'b0, ~a_hi, ~a_lo, 21'h0ABCD}, 24, 4'h0, 4'h0, 4'h0);
        xfer(wd(dacwd_pkg::SEL_DAC, 2'h0, 16'h5555) >> 1, 23, 4'h0, 4'h0, 4'h0);
        xfer(wd(dacwd_pkg::SEL_DAC, 2'h0, 16'h5555) | 32'h0080_0000, 24, 4'h0, 4'h0, 4'h1);
        @(negedge clk) {a_hi, a_lo} = 2'b01;
        e_dac[15:0] = 16'h2468;
        xfer(wd(dacwd_pkg::SEL_DAC, 2'h0, 16'h2468), 24, 4'h1, 4'h0, 4'h0);
        @(negedge clk) chk_on = 1'b1;
        xfer(wd(dacwd_pkg::SEL_DAC, 2'h2, 16'h1111), 24, 4'h0, 4'h0, 4'h0);
        e_dac[63:48] = 16'h7777;
        xfer((wd(dacwd_pkg::SEL_DAC, 2'h3, 16'h7777) << 8) | 32'h0000_005A, 32, 4'h8, 4'h0, 4'h0);
        $display("refusal test done");
    endtask : t_refuse
    // closing report
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    // watchdog against a hung run
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
    // main sequence
    initial begin
        e_dac = {4{dacwd_pkg::DAC_RST}};
        e_gain = {4{dacwd_pkg::GAIN_RST}};
        e_ofs = {4{dacwd_pkg::OFS_RST}};
        e_clr = {4{dacwd_pkg::CLR_RST}};
        repeat (4) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        cmp_regs();
        t_bringup();
        t_chan();
        t_trim();
        t_refuse();
        print_verdict();
    end
endmodule : dacwd_top_test
